// ### hdl/lp_osc_clk_divider.v
// digital divider of the low-power oscillator: output toggles every (1 + ratio) analog edges
`timescale 1ns/1ps
`default_nettype none

module lp_osc_clk_divider
(
  input  wire       core_clk,
  input  wire       sys_rst,
  input  wire       enable,
  input  wire       analog_edge,
  input  wire [4:0] ratio,
  output reg        div_clk_q
);

  reg [4:0] cnt_q;

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cnt_q     <= 5'h00;
      div_clk_q <= 1'b0;
    end
    else if (!enable)
    begin
      // held quiet until software has chosen a frequency
      cnt_q     <= 5'h00;
      div_clk_q <= 1'b0;
    end
    else if (analog_edge)
    begin
      // a full period is 2 x (1 + ratio) analog periods
      // >= guards against a ratio lowered below the running count
      if (cnt_q >= ratio)
      begin
        cnt_q     <= 5'h00;
        div_clk_q <= ~div_clk_q;
      end
      else
      begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

endmodule
`default_nettype wire

// ### hdl/pll_lock_model.v
// lock detector model: counts reference edges after a restart before reporting lock
`timescale 1ns/1ps
`default_nettype none
`include "pll_osc_regs.vh"

module pll_lock_model
(
  input  wire       core_clk,
  input  wire       sys_rst,
  input  wire       restart,
  input  wire       ref_edge,
  output reg        locked_q
);

  localparam [1:0] ST_ACQUIRE = 2'b01;
  localparam [1:0] ST_LOCKED  = 2'b10;

  reg [1:0] state_q;
  reg [9:0] cnt_q;

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_q  <= ST_ACQUIRE;
      cnt_q    <= 10'h000;
      locked_q <= 1'b0;
    end
    else if (restart)
    begin
      // any divider change drops lock at once
      state_q  <= ST_ACQUIRE;
      cnt_q    <= 10'h000;
      locked_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_ACQUIRE:
        begin
          if (ref_edge)
          begin
            if (cnt_q == `LOCK_REF_CYCLES - 10'h001)
            begin
              state_q  <= ST_LOCKED;
              locked_q <= 1'b1;
            end
            else
            begin
              cnt_q <= cnt_q + 10'h001;
            end
          end
        end
        ST_LOCKED:
        begin
          locked_q <= 1'b1;
        end
        default:
        begin
          state_q  <= ST_ACQUIRE;
          locked_q <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### hdl/pll_osc_reset_control.v
// clock and reset control: spi reset, pll dividers and lock, oscillator controls, register slave
`timescale 1ns/1ps
`default_nettype none
`include "pll_osc_regs.vh"

module pll_osc_reset_control
(
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire [31:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        crystal_input_pin,
  input  wire        sys_osc_clk,
  input  wire        lp_osc_analog_clk,
  output reg         spi_reset_n,
  output reg         pll_ref_clk,
  output reg  [5:0]  pll_feedback_factor,
  output reg  [4:0]  pll_post_ratio,
  output reg         osc_bypass,
  output reg         osc_range_select,
  output reg  [3:0]  lp_osc_analog_freq,
  output wire        lp_osc_clk,
  output wire        pll_locked,
  output reg         irq
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // clocks that arrive on pins are sampled, so they must stay well below
  // half of core_clk; a faster reference is only seen as a sampled pattern

  wire [2:0] pin_raw;
  reg  [2:0] pin_s1_q;
  reg  [2:0] pin_s2_q;
  reg  [2:0] pin_s3_q;
  reg  [2:0] pin_val_q;
  reg  [2:0] pin_prev_q;

  assign pin_raw = {lp_osc_analog_clk, sys_osc_clk, crystal_input_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_pin_sync
      always @(posedge core_clk)
      begin
        if (sys_rst)
        begin
          pin_s1_q[gi]   <= 1'b0;
          pin_s2_q[gi]   <= 1'b0;
          pin_s3_q[gi]   <= 1'b0;
          pin_val_q[gi]  <= 1'b0;
          pin_prev_q[gi] <= 1'b0;
        end
        else
        begin
          pin_s1_q[gi]   <= pin_raw[gi];
          pin_s2_q[gi]   <= pin_s1_q[gi];
          pin_s3_q[gi]   <= pin_s2_q[gi];
          pin_prev_q[gi] <= pin_val_q[gi];
          if (pin_s2_q[gi] == pin_s3_q[gi])
          begin
            pin_val_q[gi] <= pin_s3_q[gi];
          end
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // register state

  reg       spi_release_q;
  reg [4:0] fb_div_q;
  reg [1:0] post_code_q;
  reg       bypass_q;
  reg       range_q;
  reg [4:0] lp_div_q;
  reg [3:0] lp_freq_q;
  reg       lp_prog_q;
  reg [1:0] irq_status_q;
  reg [1:0] irq_mask_q;
  reg       restart_q;
  reg       lock_prev_q;

  wire [31:0] be_mask;
  wire [31:0] wr_merge_pll;
  wire [31:0] wr_merge_lp;
  wire        bus_req;
  wire        bus_commit_wr;
  wire        hit_periph;
  wire        hit_pll_cfg;
  wire        hit_pll_stat;
  wire        hit_sys_osc;
  wire        hit_lp_osc;
  wire        hit_irq_stat;
  wire        hit_irq_mask;

  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  assign hit_periph   = (avs_address == `PERIPH_RST_ADDR);
  assign hit_pll_cfg  = (avs_address == `PLL_CFG_ADDR);
  assign hit_pll_stat = (avs_address == `PLL_STAT_ADDR);
  assign hit_sys_osc  = (avs_address == `SYS_OSC_ADDR);
  assign hit_lp_osc   = (avs_address == `LP_OSC_ADDR);
  assign hit_irq_stat = (avs_address == `IRQ_STATUS_ADDR);
  assign hit_irq_mask = (avs_address == `IRQ_MASK_ADDR);

  assign bus_req       = avs_read | avs_write;
  // a write lands on the edge where the master sees waitrequest low
  assign bus_commit_wr = avs_write & ~avs_waitrequest;

  // reserved bits are never stored, so stray ones read back as zero
  assign wr_merge_pll = ({25'h000_0000, post_code_q, fb_div_q} & ~be_mask)
                        | (avs_writedata & be_mask);
  assign wr_merge_lp  = ({23'h00_0000, lp_freq_q, lp_div_q} & ~be_mask)
                        | (avs_writedata & be_mask);

  wire pll_cfg_change;
  assign pll_cfg_change = bus_commit_wr & hit_pll_cfg &
    ((wr_merge_pll[`FB_DIV_MSB:`FB_DIV_LSB] != fb_div_q) |
     (wr_merge_pll[`POST_DIV_MSB:`POST_DIV_LSB] != post_code_q));

  wire bypass_change;
  assign bypass_change = bus_commit_wr & hit_sys_osc & avs_byteenable[0] &
    (avs_writedata[`BYPASS_BIT] != bypass_q);

  //////////////////////////////////////////////////////////////////////////////
  // register writes

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      spi_release_q <= `SPI_RELEASE_RESET;
      fb_div_q      <= `FB_DIV_RESET;
      post_code_q   <= `POST_DIV_RESET;
      bypass_q      <= `BYPASS_RESET;
      range_q       <= `RANGE_RESET;
      lp_div_q      <= `LP_DIV_RESET;
      lp_freq_q     <= `LP_FREQ_RESET;
      lp_prog_q     <= 1'b0;
      irq_mask_q    <= `IRQ_RESET;
      restart_q     <= 1'b0;
    end
    else
    begin
      restart_q <= pll_cfg_change | bypass_change;
      if (bus_commit_wr)
      begin
        if (hit_periph && avs_byteenable[0])
        begin
          spi_release_q <= avs_writedata[`SPI_RELEASE_BIT];
        end
        if (hit_pll_cfg)
        begin
          fb_div_q    <= wr_merge_pll[`FB_DIV_MSB:`FB_DIV_LSB];
          post_code_q <= wr_merge_pll[`POST_DIV_MSB:`POST_DIV_LSB];
        end
        if (hit_sys_osc && avs_byteenable[0])
        begin
          bypass_q <= avs_writedata[`BYPASS_BIT];
          range_q  <= avs_writedata[`RANGE_BIT];
        end
        if (hit_lp_osc && (avs_byteenable[1:0] != 2'h0))
        begin
          lp_div_q  <= wr_merge_lp[`LP_DIV_MSB:`LP_DIV_LSB];
          lp_freq_q <= wr_merge_lp[`LP_FREQ_MSB:`LP_FREQ_LSB];
          lp_prog_q <= 1'b1;
        end
        if (hit_irq_mask && avs_byteenable[0])
        begin
          irq_mask_q <= avs_writedata[1:0];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pll reference, dividers and lock

  wire ref_sel;
  wire ref_edge;

  // bypass takes the crystal pin straight through, else the oscillator
  assign ref_sel  = bypass_q ? pin_val_q[0] : pin_val_q[1];
  assign ref_edge = bypass_q ? (pin_val_q[0] & ~pin_prev_q[0])
                             : (pin_val_q[1] & ~pin_prev_q[1]);

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pll_ref_clk         <= 1'b0;
      pll_feedback_factor <= 6'h01;
      pll_post_ratio      <= 5'h02;
      spi_reset_n         <= 1'b0;
      osc_bypass          <= `BYPASS_RESET;
      osc_range_select    <= `RANGE_RESET;
      lp_osc_analog_freq  <= `LP_FREQ_RESET;
    end
    else
    begin
      pll_ref_clk         <= ref_sel;
      // the analog loop multiplies by M, then divides by 2P
      pll_feedback_factor <= {1'b0, fb_div_q} + 6'h01;
      pll_post_ratio      <= 5'h02 << post_code_q;
      spi_reset_n         <= spi_release_q;
      osc_bypass          <= bypass_q;
      osc_range_select    <= range_q;
      lp_osc_analog_freq  <= lp_freq_q;
    end
  end

  pll_lock_model u_lock
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .restart  (restart_q),
    .ref_edge (ref_edge),
    .locked_q (pll_locked)
  );

  //////////////////////////////////////////////////////////////////////////////
  // low-power oscillator output divider

  lp_osc_clk_divider u_lp_div
  (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .enable      (lp_prog_q),
    .analog_edge (pin_val_q[2] & ~pin_prev_q[2]),
    .ratio       (lp_div_q),
    .div_clk_q   (lp_osc_clk)
  );

  //////////////////////////////////////////////////////////////////////////////
  // lock events and interrupt

  wire [1:0] irq_set;
  wire [1:0] irq_clr;
  wire [1:0] irq_status_d;

  assign irq_set      = {lock_prev_q & ~pll_locked, ~lock_prev_q & pll_locked};
  assign irq_clr      = (bus_commit_wr && hit_irq_stat && avs_byteenable[0])
                        ? avs_writedata[1:0] : 2'h0;
  // a new event outranks a clear in the same cycle
  assign irq_status_d = (irq_status_q & ~irq_clr) | irq_set;

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      lock_prev_q  <= 1'b0;
      irq_status_q <= `IRQ_RESET;
      irq          <= 1'b0;
    end
    else
    begin
      lock_prev_q  <= pll_locked;
      irq_status_q <= irq_status_d;
      irq          <= |(irq_status_d & irq_mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then a single cycle with waitrequest low

  reg [31:0] rd_mux;

  always @*
  begin
    rd_mux = 32'h0000_0000;
    if (hit_periph)
    begin
      rd_mux[`SPI_RELEASE_BIT] = spi_release_q;
    end
    else if (hit_pll_cfg)
    begin
      rd_mux[`POST_DIV_MSB:`FB_DIV_LSB] = {post_code_q, fb_div_q};
    end
    else if (hit_pll_stat)
    begin
      rd_mux[`LOCK_BIT] = pll_locked;
    end
    else if (hit_sys_osc)
    begin
      rd_mux[`RANGE_BIT:`BYPASS_BIT] = {range_q, bypass_q};
    end
    else if (hit_lp_osc)
    begin
      rd_mux[`LP_FREQ_MSB:`LP_DIV_LSB] = {lp_freq_q, lp_div_q};
    end
    else if (hit_irq_stat)
    begin
      rd_mux[1:0] = irq_status_q;
    end
    else if (hit_irq_mask)
    begin
      rd_mux[1:0] = irq_mask_q;
    end
  end

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else if (bus_req && avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// ### pkg/pll_osc_regs.vh
// register map, field positions, reset values and timing counts of the clock control block
`ifndef PLL_OSC_REGS_VH
`define PLL_OSC_REGS_VH

// byte addresses on the register bus
`define PERIPH_RST_ADDR     32'h4004_8004
`define PLL_CFG_ADDR        32'h4004_8008
`define PLL_STAT_ADDR       32'h4004_800c
`define SYS_OSC_ADDR        32'h4004_8020
`define LP_OSC_ADDR         32'h4004_8024
`define IRQ_STATUS_ADDR     32'h4004_8f00
`define IRQ_MASK_ADDR       32'h4004_8f04

// field positions
`define SPI_RELEASE_BIT     0
`define FB_DIV_MSB          4
`define FB_DIV_LSB          0
`define POST_DIV_MSB        6
`define POST_DIV_LSB        5
`define LOCK_BIT            0
`define BYPASS_BIT          0
`define RANGE_BIT           1
`define LP_DIV_MSB          4
`define LP_DIV_LSB          0
`define LP_FREQ_MSB         8
`define LP_FREQ_LSB         5
`define IRQ_LOCK_GAIN_BIT   0
`define IRQ_LOCK_LOSS_BIT   1

// reset values
`define SPI_RELEASE_RESET   1'b0
`define FB_DIV_RESET        5'h00
`define POST_DIV_RESET      2'h0
`define BYPASS_RESET        1'b0
`define RANGE_RESET         1'b0
`define LP_DIV_RESET        5'h00
`define LP_FREQ_RESET       4'h0
`define IRQ_RESET           2'h0

// reference clock edges from a divider change until lock is reported
`define LOCK_REF_CYCLES     10'h064

`endif

// ### verif/pll_osc_checker.sv
// concurrent checks on the ports of the clock and reset control block
`timescale 1ns/1ps
`default_nettype none
`include "pll_osc_regs.vh"
////////////////////////////////////////////////////////////////////////////////
module pll_osc_checker
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [31:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        spi_reset_n,
  input wire logic [5:0]  pll_feedback_factor,
  input wire logic [4:0]  pll_post_ratio,
  input wire logic        osc_bypass,
  input wire logic        osc_range_select,
  input wire logic [3:0]  lp_osc_analog_freq,
  input wire logic        pll_locked
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // a full-word write that the slave accepts in this cycle
  sequence s_wr(a);
    avs_write && !avs_waitrequest && avs_byteenable == 4'hf && avs_address == a;
  endsequence
  // lock lost must stay lost for at least eight cycles
  sequence s_low8;
    !pll_locked [*8];
  endsequence
  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not low for exactly one cycle");
  a_read_idle: assert property (
    avs_waitrequest |-> avs_readdata == 32'h0000_0000)
    else $error("readdata not zero while waiting");
  a_stat_rsvd: assert property (
    avs_read && !avs_waitrequest && avs_address == `PLL_STAT_ADDR |-> avs_readdata[31:1] == 0)
    else $error("lock status reserved bits not zero");
  a_spi_release: assert property (
    s_wr(`PERIPH_RST_ADDR) ##0 avs_writedata[0] |-> ##2 spi_reset_n)
    else $error("spi reset not released");
  a_spi_hold: assert property (
    !$stable(spi_reset_n) |-> $past(avs_write, 2))
    else $error("spi reset moved without a write");
  a_fb_map: assert property (
    s_wr(`PLL_CFG_ADDR) |-> ##2
      pll_feedback_factor == {1'b0, $past(avs_writedata[4:0], 2)} + 6'h01)
    else $error("feedback factor wrong");
  a_post_map: assert property (
    s_wr(`PLL_CFG_ADDR) |-> ##2 pll_post_ratio == (5'h02 << $past(avs_writedata[6:5], 2)))
    else $error("post ratio wrong");
  a_osc_map: assert property (
    s_wr(`SYS_OSC_ADDR) |-> ##2 osc_bypass == $past(avs_writedata[0], 2)
      && osc_range_select == $past(avs_writedata[1], 2))
    else $error("oscillator controls wrong");
  a_freq_map: assert property (
    s_wr(`LP_OSC_ADDR) |-> ##2 lp_osc_analog_freq == $past(avs_writedata[8:5], 2))
    else $error("analog frequency select wrong");
  a_lock_hold: assert property (
    $fell(pll_locked) |-> s_low8)
    else $error("lock came back too soon");
endmodule
bind pll_osc_reset_control pll_osc_checker i_chk (.core_clk, .sys_rst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .spi_reset_n, .pll_feedback_factor, .pll_post_ratio, .osc_bypass, .osc_range_select,
  .lp_osc_analog_freq, .pll_locked);
`default_nettype wire

// ### verif/tb_pll_osc_reset_control.sv
// self-checking bench of the clock and reset control block
`timescale 1ns/1ps
`default_nettype none
`include "pll_osc_regs.vh"
////////////////////////////////////////////////////////////////////////////////
module tb_pll_osc_reset_control;
  reg         core_clk, sys_rst, avs_read, avs_write;
  reg  [31:0] avs_address, avs_writedata, rd;
  reg  [3:0]  ph, be;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, spi_reset_n, pll_ref_clk, osc_bypass, osc_range_select;
  wire        lp_osc_clk, pll_locked, irq;
  wire [5:0]  pll_feedback_factor;
  wire [4:0]  pll_post_ratio;
  wire [3:0]  lp_osc_analog_freq;
  integer     n_mismatch, checked, cyc, n;
  pll_osc_reset_control i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .crystal_input_pin(ph[3]), .sys_osc_clk(ph[2]),
    .lp_osc_analog_clk(ph[2]), .spi_reset_n(spi_reset_n), .pll_ref_clk(pll_ref_clk),
    .pll_feedback_factor(pll_feedback_factor), .pll_post_ratio(pll_post_ratio),
    .osc_bypass(osc_bypass), .osc_range_select(osc_range_select),
    .lp_osc_analog_freq(lp_osc_analog_freq), .lp_osc_clk(lp_osc_clk),
    .pll_locked(pll_locked), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // slow reference clocks: sys osc and analog every 8 cycles, external pin every 16
  always @(posedge core_clk)
  begin
    ph <= ph + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      stop_test;
    end
  end
  task stop_test;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_rng(input integer got, input integer lo, input integer hi);
    begin
      checked = checked + 1;
      if (got < lo || got > hi)
      begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
    end
  endtask
  // one access: hold everything until waitrequest is seen low, then release
  task bus(input wr, input [31:0] a, input [31:0] d);
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge core_clk);
      // no local limit: only the cycle ceiling ends a hung access
      while (avs_waitrequest !== 1'b0)
      begin
        @(posedge core_clk);
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  // rising edges of the reference (0) or low-power output (1) over a window
  task rises(input integer sel, input integer win, output integer cnt);
    integer i;
    reg p, s;
    begin
      cnt = 0;
      p = sel ? lp_osc_clk : pll_ref_clk;
      for (i = 0; i < win; i = i + 1)
      begin
        @(posedge core_clk);
        s = sel ? lp_osc_clk : pll_ref_clk;
        if (s && !p)
          cnt = cnt + 1;
        p = s;
      end
    end
  endtask
  task wait_lock(output integer w);
    begin
      w = 0;
      while (pll_locked !== 1'b1 && w < 3000)
      begin
        @(posedge core_clk);
        w = w + 1;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    begin
      chk({26'h0, pll_feedback_factor}, 32'h0000_0001);
      chk({27'h0, pll_post_ratio}, 32'h0000_0002);
      chk({29'h0, spi_reset_n, lp_osc_clk, pll_locked}, 32'h0000_0000);
      bus(0, `PERIPH_RST_ADDR, 0); chk(rd, 32'h0000_0000);
      bus(0, `PLL_CFG_ADDR, 0); chk(rd, 32'h0000_0000);
      bus(0, `PLL_STAT_ADDR, 0); chk(rd, 32'h0000_0000);
      bus(0, `SYS_OSC_ADDR, 0); chk(rd, 32'h0000_0000);
      bus(0, `LP_OSC_ADDR, 0); chk(rd, 32'h0000_0000);
      bus(0, 32'h4004_8010, 0); chk(rd, 32'h0000_0000);
    end
  endtask
  task t_spi;
    begin
      bus(1, `PERIPH_RST_ADDR, 1); repeat (3) @(posedge core_clk);
      chk({31'h0, spi_reset_n}, 32'h0000_0001);
      bus(0, `PERIPH_RST_ADDR, 0); chk(rd, 32'h0000_0001);
      bus(1, `PERIPH_RST_ADDR, 0); repeat (3) @(posedge core_clk);
      chk({31'h0, spi_reset_n}, 32'h0000_0000);
      bus(1, `PERIPH_RST_ADDR, 1);
    end
  endtask
  task t_cfg;
    integer c;
    reg [4:0] fb;
    begin
      for (c = 0; c < 4; c = c + 1)
      begin
        fb = (c == 3) ? 5'h1f : c * 10;
        bus(1, `PLL_CFG_ADDR, {25'h0, c[1:0], fb}); repeat (3) @(posedge core_clk);
        chk({26'h0, pll_feedback_factor}, fb + 32'h0000_0001);
        chk({27'h0, pll_post_ratio}, 32'h0000_0002 << c);
        bus(0, `PLL_CFG_ADDR, 0); chk(rd, {25'h0, c[1:0], fb});
      end
    end
  endtask
  task t_lock;
    begin
      bus(1, `IRQ_MASK_ADDR, 0); wait_lock(n);
      chk({31'h0, pll_locked}, 32'h0000_0001);
      bus(0, `PLL_STAT_ADDR, 0); chk(rd, 32'h0000_0001);
      bus(1, `PLL_STAT_ADDR, 0); bus(0, `PLL_STAT_ADDR, 0); chk(rd, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0000);
      bus(0, `IRQ_STATUS_ADDR, 0); chk(rd & 32'h0000_0001, 32'h0000_0001);
      bus(1, `IRQ_MASK_ADDR, 1); repeat (3) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0000_0001);
      bus(1, `IRQ_STATUS_ADDR, 3); repeat (3) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0000_0000);
      bus(1, `PLL_CFG_ADDR, 32'h0000_0005); repeat (4) @(posedge core_clk);
      chk({31'h0, pll_locked}, 32'h0000_0000);
      bus(0, `PLL_STAT_ADDR, 0); chk(rd, 32'h0000_0000);
      wait_lock(n); chk_rng(n, 760, 810);
      repeat (3) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0000_0001);
      bus(1, `IRQ_STATUS_ADDR, 3);
    end
  endtask
  task t_osc;
    begin
      rises(0, 320, n); chk_rng(n, 39, 41);
      bus(1, `SYS_OSC_ADDR, 3); repeat (6) @(posedge core_clk);
      rises(0, 320, n); chk_rng(n, 19, 21);
      chk({30'h0, osc_range_select, osc_bypass}, 32'h0000_0003);
      bus(0, `SYS_OSC_ADDR, 0); chk(rd, 32'h0000_0003);
      bus(1, `SYS_OSC_ADDR, 0);
    end
  endtask
  task t_lp;
    integer d;
    begin
      for (d = 0; d < 2; d = d + 1)
      begin
        bus(1, `LP_OSC_ADDR, {23'h0, d ? 4'hf : 4'h1, 4'h0, d[0]});
        repeat (8) @(posedge core_clk);
        rises(1, 320, n); chk_rng(n, 19 / (d + 1), 21 / (d + 1));
        chk({28'h0, lp_osc_analog_freq}, d ? 32'h0000_000f : 32'h0000_0001);
      end
      // only byte lane 1 enabled: bit 8 clears, the rest of the word stays
      be <= 4'h2;
      bus(1, `LP_OSC_ADDR, 32'h0000_0000);
      be <= 4'hf;
      bus(0, `LP_OSC_ADDR, 0); chk(rd, 32'h0000_00e1);
      chk({28'h0, lp_osc_analog_freq}, 32'h0000_0007);
    end
  endtask
  initial
  begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 32'h0000_0000;
    avs_writedata = 32'h0000_0000;
    ph = 4'h0;
    be = 4'hf;
    cyc = 0;
    n_mismatch = 0;
    checked = 0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_reset;
    t_spi;
    t_cfg;
    t_lock;
    t_osc;
    t_lp;
    stop_test;
  end
endmodule
`default_nettype wire
